//--- core/cpis_decoder.sv
// Pulse decoder: turns the selected pulse format into up/down strobes
`timescale 1ns/1ps
module cpis_decoder
  import cpis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  output logic up_o,
  output logic down_o
);
  typedef struct packed {
    logic a;
    logic b;
    logic up;
    logic down;
  } cpis_dec_t;
  cpis_dec_t s_q, s_d;
  logic a_rise, b_rise, a_chg, b_chg;
  always_comb
  begin
    s_d = s_q;
    s_d.a = pulse_a_i;
    s_d.b = pulse_b_i;
    s_d.up = 1'b0;
    s_d.down = 1'b0;
    a_rise = pulse_a_i & ~s_q.a;
    b_rise = pulse_b_i & ~s_q.b;
    a_chg = pulse_a_i ^ s_q.a;
    b_chg = pulse_b_i ^ s_q.b;
    case (mode_i)
      CPIS_MODE_QUAD0, CPIS_MODE_QUAD2:
      begin
        // X4 decode; a simultaneous change of both phases is illegal, dropped
        if (a_chg && !b_chg)
        begin
          s_d.up = pulse_a_i ^ s_q.b;
          s_d.down = ~(pulse_a_i ^ s_q.b);
        end
        else if (b_chg && !a_chg)
        begin
          s_d.up = ~(pulse_b_i ^ s_q.a);
          s_d.down = pulse_b_i ^ s_q.a;
        end
      end
      CPIS_MODE_CWCCW:
      begin
        // Both trains rising together cancel out
        s_d.up = a_rise & ~b_rise;
        s_d.down = b_rise & ~a_rise;
      end
      default:
      begin
        // Direction is sampled on the pulse edge; low means positive
        s_d.up = a_rise & ~pulse_b_i;
        s_d.down = a_rise & pulse_b_i;
      end
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign up_o = s_q.up;
  assign down_o = s_q.down;
endmodule : cpis_decoder

//--- core/cpis_top.sv
// Top: Wishbone registers, mode select, direction and probe polarity
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module cpis_top
  import cpis_pkg::*;
#(
  parameter int CNT_W = CPIS_CNT_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic probe1_i,
  input wire logic probe2_i,
  output logic probe1_o,
  output logic probe2_o,
  output logic fieldbus_mode_o,
  output logic step_valid_o,
  output logic step_neg_o,
  output logic [CNT_W-1:0] position_o
);
  import cpis_pkg::*;
  initial
  begin
    if (CNT_W < 2 || CNT_W > 32)
      $error("CNT_W must lie in 2..32");
  end
  typedef struct packed {
    logic [15:0] dir_inv;
    logic [15:0] pulse_mode;
    logic [15:0] ctrl_mode;
    logic [15:0] host_pol;
    logic [CNT_W-1:0] pos;
    logic step_valid;
    logic step_neg;
    logic probe1;
    logic probe2;
    logic ack;
    logic err;
    logic [31:0] rdat;
  } cpis_state_t;
  cpis_state_t s_q, s_d;
  logic up, down, fieldbus, invert, sel_ok, hit;
  logic [1:0] pulse_mode_eff;
  logic [31:0] rd;
  // Byte-enable merge, used for every writable register
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = dat[7:0];
    if (sel[1])
      r[15:8] = dat[15:8];
    return r;
  endfunction : wmerge
  assign fieldbus = s_q.ctrl_mode[3:0] == CPIS_CTRL_FIELDBUS
                    && s_q.ctrl_mode[15:4] == 12'h000;
  // Inversion setting, when set, overrides host polarity object; when clear, host polarity decides
  assign invert = s_q.dir_inv[0]
                  | (~s_q.dir_inv[0] & s_q.host_pol[CPIS_HOST_POL_BIT]);
  // The decoder always follows pulse_mode, also in fieldbus mode; there its strobes are not counted
  assign pulse_mode_eff = s_q.pulse_mode[1:0];
  cpis_decoder u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(pulse_mode_eff),
    .pulse_a_i(pulse_a_i),
    .pulse_b_i(pulse_b_i),
    .up_o(up),
    .down_o(down)
  );
  always_comb
  begin
    hit = 1'b1;
    if (wb_adr_i == CPIS_ADDR_DIR_INV)
      rd = {16'h0000, s_q.dir_inv};
    else if (wb_adr_i == CPIS_ADDR_PULSE_MODE)
      rd = {16'h0000, s_q.pulse_mode};
    else if (wb_adr_i == CPIS_ADDR_CTRL_MODE)
      rd = {16'h0000, s_q.ctrl_mode};
    else if (wb_adr_i == CPIS_ADDR_HOST_POL)
      rd = {16'h0000, s_q.host_pol};
    else if (wb_adr_i == CPIS_ADDR_COUNT)
      rd = 32'(s_q.pos);
    else if (wb_adr_i == CPIS_ADDR_PROBE)
      rd = {30'h00000000, s_q.probe2, s_q.probe1};
    else
    begin
      rd = 32'h00000000;
      hit = 1'b0;
    end
  end
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    s_d.step_valid = 1'b0;
    sel_ok = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
    if (sel_ok)
    begin
      s_d.ack = hit;
      s_d.err = ~hit;
      s_d.rdat = rd;
      if (wb_we_i && hit)
      begin
        if (wb_adr_i == CPIS_ADDR_DIR_INV)
          s_d.dir_inv = wmerge(s_q.dir_inv, wb_dat_i, wb_sel_i) & 16'h0001;
        else if (wb_adr_i == CPIS_ADDR_PULSE_MODE)
          s_d.pulse_mode = wmerge(s_q.pulse_mode, wb_dat_i, wb_sel_i)
                           & 16'h0003;
        else if (wb_adr_i == CPIS_ADDR_CTRL_MODE)
          s_d.ctrl_mode = wmerge(s_q.ctrl_mode, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == CPIS_ADDR_HOST_POL)
          s_d.host_pol = wmerge(s_q.host_pol, wb_dat_i, wb_sel_i);
      end
    end
    // Pulses counted only outside fieldbus mode
    if (!fieldbus && (up || down))
    begin
      s_d.step_valid = 1'b1;
      s_d.step_neg = down ^ invert;
      if (down ^ invert)
        s_d.pos = s_q.pos - CNT_W'(1);
      else
        s_d.pos = s_q.pos + CNT_W'(1);
    end
    // Probe polarity: outside fieldbus mode probes pass unchanged
    s_d.probe1 = probe1_i;
    s_d.probe2 = probe2_i;
    if (fieldbus)
    begin
      case (s_q.pulse_mode[1:0])
        CPIS_PROBE_INV_BOTH:
        begin
          s_d.probe1 = ~probe1_i;
          s_d.probe2 = ~probe2_i;
        end
        CPIS_PROBE_INV_2: s_d.probe2 = ~probe2_i;
        CPIS_PROBE_INV_1: s_d.probe1 = ~probe1_i;
        default: s_d.probe1 = probe1_i;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.dir_inv <= CPIS_RST_DIR_INV;
      s_q.pulse_mode <= CPIS_RST_PULSE_MODE;
      s_q.ctrl_mode <= CPIS_RST_CTRL_MODE;
      s_q.host_pol <= CPIS_RST_HOST_POL;
    end
    else
      s_q <= s_d;
  end
  assign wb_ack_o = s_q.ack;
  assign wb_err_o = s_q.err;
  assign wb_dat_o = s_q.rdat;
  assign probe1_o = s_q.probe1;
  assign probe2_o = s_q.probe2;
  assign fieldbus_mode_o = fieldbus;
  assign step_valid_o = s_q.step_valid;
  assign step_neg_o = s_q.step_neg;
  assign position_o = s_q.pos;
endmodule : cpis_top

//--- pkg/cpis_pkg.sv
// Package: register map, reset values and mode codes for pulse input select
package cpis_pkg;
  localparam logic [15:0] CPIS_ADDR_DIR_INV = 16'h2006;
  localparam logic [15:0] CPIS_ADDR_PULSE_MODE = 16'h2007;
  localparam logic [15:0] CPIS_ADDR_CTRL_MODE = 16'h2001;
  localparam logic [15:0] CPIS_ADDR_HOST_POL = 16'h2010;
  localparam logic [15:0] CPIS_ADDR_COUNT = 16'h2011;
  localparam logic [15:0] CPIS_ADDR_PROBE = 16'h2012;
  localparam logic [15:0] CPIS_RST_DIR_INV = 16'h0000;
  localparam logic [15:0] CPIS_RST_PULSE_MODE = 16'h0003;
  localparam logic [15:0] CPIS_RST_CTRL_MODE = 16'h0000;
  localparam logic [15:0] CPIS_RST_HOST_POL = 16'h0000;
  localparam logic [3:0] CPIS_CTRL_FIELDBUS = 4'h9;
  localparam int CPIS_MODE_W = 2;
  localparam logic [1:0] CPIS_MODE_QUAD0 = 2'h0;
  localparam logic [1:0] CPIS_MODE_CWCCW = 2'h1;
  localparam logic [1:0] CPIS_MODE_QUAD2 = 2'h2;
  localparam logic [1:0] CPIS_MODE_PULSEDIR = 2'h3;
  localparam logic [1:0] CPIS_PROBE_INV_BOTH = 2'h0;
  localparam logic [1:0] CPIS_PROBE_INV_2 = 2'h1;
  localparam logic [1:0] CPIS_PROBE_INV_1 = 2'h2;
  localparam int CPIS_HOST_POL_BIT = 7;
  localparam int CPIS_CNT_W = 32;
endpackage : cpis_pkg

//--- verif/cpis_assertions.sv
// Checker: port-level assertions for the pulse input select block
`timescale 1ns/1ps
module cpis_assertions
  import cpis_pkg::*;
#(
  parameter int CNT_W = CPIS_CNT_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic probe1_i,
  input wire logic probe2_i,
  input wire logic probe1_o,
  input wire logic probe2_o,
  input wire logic fieldbus_mode_o,
  input wire logic step_valid_o,
  input wire logic step_neg_o,
  input wire logic [CNT_W-1:0] position_o
);
  // Shadows follow writes on the edge that takes them, as the block does
  logic [15:0] c_q;
  logic [1:0] m_q;
  logic d_q, h_q, inv;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c_q <= 16'h0;
      m_q <= 2'h3;
      d_q <= 1'h0;
      h_q <= 1'h0;
    end
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)
    begin
      if (wb_adr_i == CPIS_ADDR_CTRL_MODE) c_q <= wb_dat_i[15:0];
      if (wb_adr_i == CPIS_ADDR_PULSE_MODE) m_q <= wb_dat_i[1:0];
      if (wb_adr_i == CPIS_ADDR_DIR_INV) d_q <= wb_dat_i[0];
      if (wb_adr_i == CPIS_ADDR_HOST_POL) h_q <= wb_dat_i[7];
    end
  end
  assign inv = d_q | h_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_probe_plain: assert property (
    !fieldbus_mode_o |=> {probe2_o, probe1_o} == $past({probe2_i, probe1_i}))
    else $error("probe altered");
  a_probe_inv: assert property (
    fieldbus_mode_o |=> {probe2_o, probe1_o} ==
    ($past({probe2_i, probe1_i}) ^ ~$past(m_q))) else $error("probe polarity");
  a_fb_level: assert property (
    fieldbus_mode_o == (c_q == 16'h0009)) else $error("fieldbus flag");
  a_fb_no_step: assert property (
    fieldbus_mode_o [*3] |-> !step_valid_o) else $error("step in fieldbus");
  a_dir_step: assert property (
    $rose(pulse_a_i) && m_q == CPIS_MODE_PULSEDIR && !fieldbus_mode_o |->
    ##2 step_valid_o && step_neg_o == (pulse_b_i ^ inv)) else $error("dir step");
  a_quad_step: assert property (
    $rose(pulse_a_i) && !pulse_b_i && !m_q[0] && !fieldbus_mode_o |->
    ##2 step_valid_o && step_neg_o == inv) else $error("quad step");
  a_cw_step: assert property (
    $rose(pulse_b_i) && !pulse_a_i && m_q == CPIS_MODE_CWCCW && !fieldbus_mode_o
    |-> ##2 step_valid_o && step_neg_o == !inv) else $error("ccw step");
  a_pos_step: assert property (
    !$past(rst_i) |-> position_o == $past(position_o) + (step_valid_o ?
    (step_neg_o ? '1 : CNT_W'(1)) : '0)) else $error("position step");
  cover property (step_valid_o && step_neg_o);
  cover property (step_valid_o && !step_neg_o);
  cover property (fieldbus_mode_o && probe1_o);
endmodule : cpis_assertions

bind cpis_top cpis_assertions #(.CNT_W(CNT_W)) i_cpis_assertions (.*);

//--- verif/cpis_ctrl_model.sv
// Motion controller model: drives the selected pulse format
`timescale 1ns/1ps
module cpis_ctrl_model
(
  input wire logic clk_i,
  output logic a_o = 1'h0,
  output logic b_o = 1'h0
);
  // Each level held 3 clocks; the block needs at least 1
  task automatic lvl(input logic a, input logic b);
    @(posedge clk_i);
    a_o <= a;
    b_o <= b;
    repeat (2) @(posedge clk_i);
  endtask : lvl
  // One step in mode 1 or 3, four quadrature edges in mode 0 or 2
  task automatic send(input logic [1:0] md, input logic neg);
    logic [7:0] s;
    if (md == 2'h3)
      s = {1'h0, neg, 1'h1, neg, 1'h0, neg, 2'h0};
    else if (md == 2'h1)
      s = {~neg, neg, 6'h0};
    else
      s = neg ? 8'h78 : 8'hB4;
    for (int i = 3; i >= 0; i--)
      lvl(s[2*i+1], s[2*i]);
  endtask : send
endmodule : cpis_ctrl_model

//--- verif/tb.sv
// Testbench: registers, pulse modes, direction and probe polarity
`timescale 1ns/1ps
module tb;
  import cpis_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [15:0] wb_adr_i = 16'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, position_o, rd, pe;
  logic [31:0] pos_e = 32'h0;
  logic probe1_i = 1'h0;
  logic probe2_i = 1'h0;
  logic wb_ack_o, wb_err_o, pulse_a_i, pulse_b_i, probe1_o, probe2_o;
  logic fieldbus_mode_o, step_valid_o, step_neg_o, er;
  int err_total = 0;
  int check_count = 0;
  cpis_top i_cpis_top (.*);
  cpis_ctrl_model i_cpis_ctrl_model (.clk_i(clk_i), .a_o(pulse_a_i),
    .b_o(pulse_b_i));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input string n, input logic [31:0] s,
    input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wb(input logic we, input logic [15:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, CPIS_ADDR_DIR_INV, 32'h0);
    check("dir_inv", rd, 32'h0);
    wb(1'h0, CPIS_ADDR_PULSE_MODE, 32'h0);
    check("pulse_mode", rd, 32'h3);
    wb(1'h0, 16'h2000, 32'h0);
    check("unmapped", 32'(er), 32'h1);
    wb(1'h1, CPIS_ADDR_COUNT, 32'h5);
    wb(1'h0, CPIS_ADDR_COUNT, 32'h0);
    check("count ro", rd, 32'h0);
    // Every mode, sign, inversion and host polarity combination
    for (int k = 0; k < 32; k++)
    begin
      wb(1'h1, CPIS_ADDR_PULSE_MODE, 32'(k[1:0]));
      wb(1'h1, CPIS_ADDR_DIR_INV, 32'(k[3]));
      wb(1'h1, CPIS_ADDR_HOST_POL, 32'(k[4]) << 7);
      i_cpis_ctrl_model.send(k[1:0], k[2]);
      repeat (2) @(posedge clk_i);
      pe = k[0] ? 32'h1 : 32'h4;
      pos_e = (k[2] ^ (k[3] | k[4])) ? pos_e - pe : pos_e + pe;
      check("pos", position_o, pos_e);
    end
    for (int k = 0; k < 32; k++)
    begin
      wb(1'h1, CPIS_ADDR_CTRL_MODE, k[4] ? 32'h9 : 32'h0);
      wb(1'h1, CPIS_ADDR_PULSE_MODE, 32'(k[3:2]));
      probe1_i <= k[0];
      probe2_i <= k[1];
      repeat (2) @(posedge clk_i);
      pe = {30'h0, k[1:0] ^ (k[4] ? ~k[3:2] : 2'h0)};
      check("probes", 32'({probe2_o, probe1_o}), pe);
      check("fieldbus", 32'(fieldbus_mode_o), 32'(k[4]));
      wb(1'h0, CPIS_ADDR_PROBE, 32'h0);
      check("probe reg", rd, pe);
    end
    i_cpis_ctrl_model.send(2'h3, 1'h0);
    repeat (2) @(posedge clk_i);
    check("fieldbus hold", position_o, pos_e);
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
endmodule : tb
